// [bench/sevg_source_model.sv]
// event source model standing in for the blocks that flag system events
`timescale 1ns/1ps
`default_nettype none
module sevg_source_model (
    input  wire logic           clock,
    output logic [20:0]         rst_src,
    output logic [5:0]          snmi_src,
    output logic                fram_uncorrectable,
    output logic                osc_fault,
    output logic                nmi_pin,
    output logic                dbg_in_wr,
    output sevg_pkg::sevg_word_t dbg_in_data,
    output logic                dbg_out_rd
);
    import sevg_pkg::*;
    initial begin
        {rst_src, snmi_src, fram_uncorrectable, osc_fault} = '0;
        {nmi_pin, dbg_in_wr, dbg_out_rd, dbg_in_data} = '0;
    end
    // m is {uncorrectable, osc fault, mailbox in, mailbox out}
    task automatic fire(input logic [20:0] r, input logic [5:0] s,
                        input logic [3:0] m, input sevg_word_t d);
        rst_src <= r;
        snmi_src <= s;
        {fram_uncorrectable, osc_fault, dbg_in_wr, dbg_out_rd} <= m;
        dbg_in_data <= d;
        @(posedge clock);
        rst_src <= '0;
        snmi_src <= '0;
        {fram_uncorrectable, osc_fault, dbg_in_wr, dbg_out_rd} <= 4'h0;
        // the word is not held once the strobe drops
        dbg_in_data <= ~d;
    endtask
    task automatic pin(input logic v);
        nmi_pin <= v;
    endtask
endmodule
`default_nettype wire

// [bench/sevg_top_properties.sv]
// port-level assertions of the event vector block
`timescale 1ns/1ps
`default_nettype none
module sevg_top_properties (
    input wire logic                 clock,
    input wire logic                 rst_b,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire sevg_pkg::sevg_addr_t paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic [31:0]          prdata,
    input wire logic                 pslverr,
    input wire logic [20:0]          rst_src,
    input wire sevg_pkg::sevg_word_t dbg_out_data,
    input wire logic                 irq
);
    import sevg_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // mask is not a port, so it is tracked from bus writes
    logic [2:0] mask_seen;
    logic       bo_pend;
    wire        acc = psel && penable;
    wire        bo_rd = acc && !pwrite && paddr == 12'h678;
    sequence rd_acc(a);
        acc && !pwrite && paddr == a;
    endsequence
    sequence wr_acc(a);
        acc && pwrite && paddr == a;
    endsequence
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mask_seen <= 3'h0;
            bo_pend <= 1'b0;
        end else begin
            if (acc && pwrite && paddr == 12'h688)
                mask_seen <= pwdata[2:0];
            if (rst_src[0])
                bo_pend <= 1'b1;
            else if (bo_rd && prdata[7:0] == 8'h02)
                bo_pend <= 1'b0;
        end
    end
    rst_code_ok_a: assert property (rd_acc(12'h678) |->
        prdata[31:6] == 0 && !prdata[0] && prdata[5:0] <= 6'h30
        && !(prdata[5:0] inside {6'h0C, 6'h10, 6'h12}))
        else $error("reset vector code not legal");
    snmi_code_ok_a: assert property (rd_acc(12'h670) |->
        prdata[31:5] == 0 && !prdata[0] && prdata[4:0] <= 5'h18
        && !(prdata[4:0] inside {5'h02, 5'h06, 5'h0A}))
        else $error("system nmi code not legal");
    unmi_code_ok_a: assert property (rd_acc(12'h668) |->
        prdata inside {32'h0, 32'h2, 32'h4}) else $error("user nmi code");
    brownout_first_a: assert property (rd_acc(12'h678) ##0
        $past(bo_pend) |-> prdata[7:0] == 8'h02)
        else $error("brownout not reported first");
    pready_high_a: assert property (pready) else $error("pready low");
    unmapped_err_a: assert property (acc && !pwrite && !(paddr inside {12'h668,
        12'h670, 12'h678, 12'h680, 12'h688, 12'h690, 12'h698, 12'h6A0})
        |-> pslverr && prdata == 0) else $error("unmapped read not refused");
    prdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    mask_gate_a: assert property (mask_seen == 3'h0 |-> !irq)
        else $error("irq with all sources masked");
    irq_raise_a: assert property (|rst_src && mask_seen[0] |=> irq)
        else $error("irq missing after unmasked event");
    mbox_out_a: assert property (wr_acc(12'h6A0) |=>
        dbg_out_data == $past(pwdata[15:0])) else $error("mailbox word lost");
endmodule
`default_nettype wire

// [bench/system_event_vector_generator_test.sv]
// self-checking bench of the event vector block
`timescale 1ns/1ps
`default_nettype none
module system_event_vector_generator_test;
    import sevg_pkg::*;
    localparam logic [7:0] rst_codes [21] = '{8'h02, 8'h04, 8'h06, 8'h08,
        8'h0A, 8'h0E, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20,
        8'h22, 8'h24, 8'h26, 8'h28, 8'h2A, 8'h2C, 8'h2E, 8'h30};
    localparam logic [7:0] snmi_codes [9] = '{8'h04, 8'h08, 8'h0C, 8'h0E,
        8'h10, 8'h12, 8'h14, 8'h16, 8'h18};
    logic       clock, rst_b, psel, penable, pwrite, pready, pslverr, irq;
    logic       fram_uncorrectable, osc_fault, nmi_pin, err;
    logic       dbg_in_wr, dbg_out_rd;
    sevg_addr_t paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [20:0] rst_src;
    logic [5:0]  snmi_src;
    sevg_word_t  dbg_in_data, dbg_out_data;
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;
    sevg_top dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .rst_src, .snmi_src, .fram_uncorrectable,
        .osc_fault, .nmi_pin, .dbg_in_wr, .dbg_in_data, .dbg_out_rd,
        .dbg_out_data, .irq);
    sevg_source_model src (.clock, .rst_src, .snmi_src, .fram_uncorrectable,
        .osc_fault, .nmi_pin, .dbg_in_wr, .dbg_in_data, .dbg_out_rd);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h", $time, msg, got);
        end
    endtask
    // one apb transfer, then an idle cycle so no strobe is set twice
    task automatic apb(input logic w, input sevg_addr_t a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input sevg_addr_t a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp, "read data");
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        {psel, penable, pwrite, rst_b, paddr, pwdata} = '0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(12'h678, 32'h0);
        rd(12'h670, 32'h0);
        rd(12'h668, 32'h0);
        $display("test idle done");
        src.fire('1, 6'h0, 4'h0, 16'h0);
        for (int i = 0; i < 9; i++)
            rd(12'h678, {24'h0, rst_codes[i]});
        for (int i = 9; i < 21; i++)
            rd(12'h678, {24'h0, rst_codes[i]});
        rd(12'h678, 32'h0);
        check({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, 12'h688, 32'h7);
        check({31'h0, irq}, 32'h1, "irq unmasked");
        rd(12'h680, 32'h1);
        apb(1'b1, 12'h680, 32'h1);
        check({31'h0, irq}, 32'h0, "irq cleared");
        $display("test reset vector done");
        apb(1'b1, 12'h690, 32'h1);
        src.fire('0, 6'h3F, 4'hB, 16'hBEEF);
        rd(12'h698, 32'h0000BEEF);
        rd(12'h680, 32'h2);
        for (int i = 0; i < 9; i++)
            rd(12'h670, {24'h0, snmi_codes[i]});
        rd(12'h670, 32'h0);
        rd(12'h678, 32'h0);
        apb(1'b1, 12'h690, 32'h0);
        src.fire(21'h1, 6'h0, 4'h8, 16'h0);
        rd(12'h678, 32'h02);
        rd(12'h678, 32'h1C);
        rd(12'h670, 32'h0);
        $display("test system nmi done");
        src.pin(1'b1);
        src.fire('0, 6'h0, 4'h4, 16'h0);
        repeat (4) @(posedge clock);
        rd(12'h668, 32'h02);
        rd(12'h668, 32'h04);
        rd(12'h668, 32'h0);
        rd(12'h680, 32'h7);
        src.pin(1'b0);
        $display("test user nmi done");
        apb(1'b1, 12'h6A0, 32'h1234A5A5);
        check({16'h0, dbg_out_data}, 32'hA5A5, "mailbox out");
        rd(12'h6A0, 32'h0000A5A5);
        src.fire(21'h2, 6'h0, 4'h0, 16'h0);
        apb(1'b1, 12'h678, 32'hFF);
        rd(12'h678, 32'h04);
        rd(12'h678, 32'h0);
        apb(1'b0, 12'h7FC, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rdata, 32'h0, "unmapped data");
        $display("test mailbox and refusal done");
        src.fire('1, 6'h3F, 4'hF, 16'h0);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(12'h678, 32'h0);
        rd(12'h670, 32'h0);
        rd(12'h668, 32'h0);
        check({31'h0, irq}, 32'h0, "irq after reset");
        check({16'h0, dbg_out_data}, 32'h0, "mailbox after reset");
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
bind sevg_top sevg_top_properties chk (.clock, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .rst_src,
    .dbg_out_data, .irq);
`default_nettype wire

// [hdl/sevg_defines.svh]
// register map, field positions, vector code tables of the event vector block
// What this block does
// - reset vector: brownout 02h, reset pin 04h, software brownout 06h
// - reset vector: deep sleep wake 08h, security 0Ah, high supervisor 0Eh
// - reset vector: software power-on request 14h
// - reset vector: watchdog expiry 16h, wrong watchdog key 18h
// - fram key 1Ah, uncorrectable fram 1Ch, peripheral fetch 1Eh
// - power, protection unit, clock key violations 20h, 22h, 24h
// - protection violations: ip 26h, info 28h, segments one to three 2Ah-2Eh
// - fram access time error reported as 30h
// - nmi vector: uncorrectable fram error 04h when routed to nmi
// - nmi vector: ip 08h, segment one 0Ch, two 0Eh, three 10h
// - nmi vector: vacant memory access 12h
// - nmi vector: mailbox input 14h, mailbox output 16h
// - nmi vector: corrected fram error 18h, lowest priority
// - user nmi vector: nmi pin 02h highest, oscillator fault 04h
// - word-wide mailbox between debug port and software
`ifndef SEVG_DEFINES_SVH
`define SEVG_DEFINES_SVH

`define SEVG_ADDR_W        12
`define SEVG_IDX_UNMI      10'h19A
`define SEVG_IDX_SNMI      10'h19C
`define SEVG_IDX_RST       10'h19E
`define SEVG_IDX_IRQ_STAT  10'h1A0
`define SEVG_IDX_IRQ_MASK  10'h1A2
`define SEVG_IDX_CTRL      10'h1A4
`define SEVG_IDX_MBOX_IN   10'h1A6
`define SEVG_IDX_MBOX_OUT  10'h1A8

`define SEVG_CTRL_UNCORR_NMI 0
`define SEVG_CTRL_RESET      1'b0
`define SEVG_MASK_RESET      3'h0
`define SEVG_IRQ_RST         0
`define SEVG_IRQ_SNMI        1
`define SEVG_IRQ_UNMI        2

`define SEVG_RST_N   21
`define SEVG_SNMI_N  9
`define SEVG_UNMI_N  2
`define SEVG_RST_UNCORR_IDX 10

// entry 0 is the highest priority, eight bits per entry
`define SEVG_RST_CODES {8'h30, 8'h2E, 8'h2C, 8'h2A, 8'h28, 8'h26, 8'h24, \
    8'h22, 8'h20, 8'h1E, 8'h1C, 8'h1A, 8'h18, 8'h16, 8'h14, 8'h0E, 8'h0A, \
    8'h08, 8'h06, 8'h04, 8'h02}
`define SEVG_SNMI_CODES {8'h18, 8'h16, 8'h14, 8'h12, 8'h10, 8'h0E, 8'h0C, \
    8'h08, 8'h04}
`define SEVG_UNMI_CODES {8'h04, 8'h02}

`endif

// [hdl/sevg_encoder.sv]
// priority encoder turning pending flags into a vector code
`timescale 1ns/1ps
`default_nettype none
module sevg_encoder #(
    parameter int N = 4
) (
    input  wire logic [N-1:0]   flags,
    input  wire logic [N*8-1:0] codes,
    output logic      [N-1:0]   grant,
    output logic      [7:0]     code
);
    import sevg_pkg::*;

    logic [N-1:0] lower_set;

    // lowest index wins, so only one grant bit is ever high
    assign lower_set = flags - N'(1);
    assign grant     = flags & ~lower_set;

    always_comb begin
        code = 8'h00;
        for (int i = 0; i < N; i++) begin
            // only listed codes can appear, never a reserved one
            code = code | (grant[i] ? codes[i*8 +: 8] : 8'h00);
        end
    end
endmodule
`default_nettype wire

// [hdl/sevg_pkg.sv]
// types shared by the event vector block
package sevg_pkg;
    typedef logic [7:0]  sevg_code_t;
    typedef logic [15:0] sevg_word_t;
    typedef logic [11:0] sevg_addr_t;
endpackage

// [hdl/sevg_top.sv]
// event vector generator with apb registers, mailbox and interrupt
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sevg_defines.svh"
module sevg_top (
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire sevg_pkg::sevg_addr_t    paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    input  wire logic [`SEVG_RST_N-1:0]  rst_src,
    input  wire logic [5:0]              snmi_src,
    input  wire logic                    fram_uncorrectable,
    input  wire logic                    osc_fault,
    input  wire logic                    nmi_pin,
    input  wire logic                    dbg_in_wr,
    input  wire sevg_pkg::sevg_word_t    dbg_in_data,
    input  wire logic                    dbg_out_rd,
    output sevg_pkg::sevg_word_t         dbg_out_data,
    output logic                         irq
);
    import sevg_pkg::*;

    localparam int RN = `SEVG_RST_N;
    localparam int SN = `SEVG_SNMI_N;
    localparam int UN = `SEVG_UNMI_N;

    logic [RN-1:0] rst_flags;
    logic [SN-1:0] snmi_flags;
    logic [UN-1:0] unmi_flags;
    logic [RN-1:0] rst_grant;
    logic [SN-1:0] snmi_grant;
    logic [UN-1:0] unmi_grant;
    logic [RN-1:0] rst_clr_hold;
    logic [SN-1:0] snmi_clr_hold;
    logic [UN-1:0] unmi_clr_hold;
    sevg_code_t    rst_code;
    sevg_code_t    snmi_code;
    sevg_code_t    unmi_code;
    logic [2:0]    irq_status;
    logic [2:0]    irq_mask;
    logic          uncorr_to_nmi;
    sevg_word_t    mbox_in;
    sevg_word_t    mbox_out;
    logic          pin_sync1;
    logic          pin_sync2;
    logic          pin_prev;

    // nmi pin comes from outside the clock domain: two stages first
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
            pin_prev  <= 1'b0;
        end else begin
            pin_sync1 <= nmi_pin;
            pin_sync2 <= pin_sync1;
            pin_prev  <= pin_sync2;
        end
    end

    wire pin_rise = pin_sync2 & ~pin_prev;

    // register decode, byte address is four times the index
    wire setup     = psel & ~penable;
    wire access    = psel & penable;
    wire sel_unmi  = paddr == {`SEVG_IDX_UNMI, 2'b00};
    wire sel_snmi  = paddr == {`SEVG_IDX_SNMI, 2'b00};
    wire sel_rst   = paddr == {`SEVG_IDX_RST, 2'b00};
    wire sel_stat  = paddr == {`SEVG_IDX_IRQ_STAT, 2'b00};
    wire sel_mask  = paddr == {`SEVG_IDX_IRQ_MASK, 2'b00};
    wire sel_ctrl  = paddr == {`SEVG_IDX_CTRL, 2'b00};
    wire sel_min   = paddr == {`SEVG_IDX_MBOX_IN, 2'b00};
    wire sel_mout  = paddr == {`SEVG_IDX_MBOX_OUT, 2'b00};
    wire mapped    = sel_unmi | sel_snmi | sel_rst | sel_stat | sel_mask
                   | sel_ctrl | sel_min | sel_mout;
    wire wr_ok     = access & pwrite & mapped;
    wire rd_vector = access & ~pwrite;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // event sets: the uncorrectable fram error goes to one vector only
    wire uncorr_rst  = fram_uncorrectable & ~uncorr_to_nmi;
    wire uncorr_nmi  = fram_uncorrectable & uncorr_to_nmi;
    wire [RN-1:0] rst_set;
    wire [SN-1:0] snmi_set;
    wire [UN-1:0] unmi_set;
    assign rst_set = rst_src
        | (RN'(uncorr_rst) << `SEVG_RST_UNCORR_IDX);
    assign snmi_set = {snmi_src[5],
                       dbg_out_rd, dbg_in_wr,
                       snmi_src[4],
                       snmi_src[3:0],
                       uncorr_nmi};
    assign unmi_set = {osc_fault, pin_rise};

    // clear masks of sources reported at the setup phase
    wire [RN-1:0] rst_clr  = (rd_vector & sel_rst)  ? rst_clr_hold  : '0;
    wire [SN-1:0] snmi_clr = (rd_vector & sel_snmi) ? snmi_clr_hold : '0;
    wire [UN-1:0] unmi_clr = (rd_vector & sel_unmi) ? unmi_clr_hold : '0;

    // a new event in the clearing cycle survives
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_flags  <= '0;
            snmi_flags <= '0;
            unmi_flags <= '0;
        end else begin
            rst_flags  <= (rst_flags & ~rst_clr) | rst_set;
            snmi_flags <= (snmi_flags & ~snmi_clr) | snmi_set;
            unmi_flags <= (unmi_flags & ~unmi_clr) | unmi_set;
        end
    end

    sevg_encoder #(.N(RN)) u_rst_enc (
        .flags (rst_flags),
        .codes (`SEVG_RST_CODES),
        .grant (rst_grant),
        .code  (rst_code)
    );

    sevg_encoder #(.N(SN)) u_snmi_enc (
        .flags (snmi_flags),
        .codes (`SEVG_SNMI_CODES),
        .grant (snmi_grant),
        .code  (snmi_code)
    );

    sevg_encoder #(.N(UN)) u_unmi_enc (
        .flags (unmi_flags),
        .codes (`SEVG_UNMI_CODES),
        .grant (unmi_grant),
        .code  (unmi_code)
    );

    // data and the source to clear are frozen together at setup, so a
    // higher event arriving mid-transfer is not lost unreported
    wire [31:0] rd_mux =
          sel_unmi ? {24'h0, unmi_code}
        : sel_snmi ? {24'h0, snmi_code}
        : sel_rst  ? {24'h0, rst_code}
        : sel_stat ? {29'h0, irq_status}
        : sel_mask ? {29'h0, irq_mask}
        : sel_ctrl ? {31'h0, uncorr_to_nmi}
        : sel_min  ? {16'h0, mbox_in}
        : sel_mout ? {16'h0, mbox_out}
        : 32'h0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata        <= 32'h0;
            rst_clr_hold  <= '0;
            snmi_clr_hold <= '0;
            unmi_clr_hold <= '0;
        end else if (setup) begin
            prdata        <= rd_mux;
            rst_clr_hold  <= rst_grant;
            snmi_clr_hold <= snmi_grant;
            unmi_clr_hold <= unmi_grant;
        end
    end

    // interrupt: sticky per vector group, write one to clear
    wire [2:0] irq_set = {|unmi_set, |snmi_set, |rst_set};
    wire [2:0] irq_w1c = (wr_ok & sel_stat) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & ~irq_w1c) | irq_set;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask      <= `SEVG_MASK_RESET;
            uncorr_to_nmi <= `SEVG_CTRL_RESET;
        end else if (wr_ok & sel_mask) begin
            irq_mask <= pwdata[2:0];
        end else if (wr_ok & sel_ctrl) begin
            uncorr_to_nmi <= pwdata[`SEVG_CTRL_UNCORR_NMI];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // mailbox: debugger fills the in word, software fills the out word
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mbox_in <= 16'h0000;
        end else if (dbg_in_wr) begin
            mbox_in <= dbg_in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mbox_out <= 16'h0000;
        end else if (wr_ok & sel_mout) begin
            mbox_out <= pwdata[15:0];
        end
    end

    assign dbg_out_data = mbox_out;
endmodule
`default_nettype wire
